// >>> rtl/kst_pkg.sv
// Shared constants and types for the keyboard scanner and serial sender
package kst_pkg;
    localparam int CLK_MHZ = 100;
    localparam int US_CYC = CLK_MHZ * 1; // Cycles in one microsecond
    localparam int POR_MS = 150;
    localparam int TEST_MS = 300;
    localparam int SCAN_MS = 10;
    localparam int RPT_DLY_MS = 500;
    localparam int RPT_HZ = 11;
    localparam int T_LOW_US = 41;
    localparam int T_HIGH_US = 35;
    localparam int T_HBT_US = 20;
    localparam int FIFO_DEPTH = 16;
    localparam int FRAME_BITS = 11;
    localparam logic [3:0] PAR_BIT = 4'h9;
    localparam logic [7:0] CODE_PASS = 8'haa;
    localparam logic [7:0] CODE_FAIL = 8'hfc;
    localparam logic [7:0] OVR_SET1 = 8'hff;
    localparam logic [7:0] OVR_SET23 = 8'h00;
    localparam logic [7:0] BRK_PFX = 8'hf0;
    localparam logic [7:0] BRK_BIT1 = 8'h80;
    localparam logic [7:0] MK_BASE1 = 8'h01;
    localparam logic [7:0] MK_BASE23 = 8'h10;
    typedef enum logic [1:0] {SET1, SET2, SET3} kst_set_e;
    typedef enum logic [1:0] {KM_MKBRK, KM_MKONLY, KM_BRKONLY, KM_RPT}
        kst_kmode_e;
    typedef enum logic [1:0] {S_RESP, S_FIFO, S_OVR, S_RPT} kst_src_e;
    typedef struct packed {
        logic clk;
        logic dat;
    } kst_lin_s;
    typedef struct packed {
        logic clkOut;
        logic clkOeN;
        logic datOut;
        logic datOeN;
    } kst_lout_s;
endpackage : kst_pkg

// >>> rtl/kst_keyboard.sv
// Keyboard scanner, startup test, scan code queue and serial sender
module kst_fifo
    import kst_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Sync reset
    input wire logic inValid, // Write request
    output logic inReady, // Room for a word
    input wire logic [WIDTH-1:0] inData, // Write data
    output logic outValid, // Word available
    input wire logic outReady, // Pop request
    output logic [WIDTH-1:0] outData, // Head word
    output logic [$clog2(DEPTH):0] count // Words held
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic wr, rd;

    // Flags come from the fill count; pointers wrap, so DEPTH is a power of 2
    always_comb begin
        inReady = cnt_q != (AW+1)'(DEPTH);
        outValid = cnt_q != '0;
        outData = mem_q[rp_q];
        count = cnt_q;
        wr = inValid && inReady;
        rd = outValid && outReady;
        wp_d = wr ? wp_q + AW'(1) : wp_q;
        rp_d = rd ? rp_q + AW'(1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end

    // Pointers and count; storage needs no reset since count guards it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
        if (wr) begin
            mem_q[wp_q] <= inData;
        end
    end
endmodule : kst_fifo

// What this block does
// - Scan all keys every 10 ms while still serving the serial link.
// - Send a make code on key press, a break code on release.
// - The pause key sends a make code only, never a break code.
// - Startup reset comes 150 ms to 2 s after power is applied.
// - Self-test checks for shorted keys and ends within 300 to 500 ms.
// - On self-test failure send an error code, then halt until a command.
// - The self-test failure code is FCh.
// - After a passing self-test send AAh, and only then start scanning.
// - Outgoing scan code bytes wait in a 16-byte FIFO.
// - Responses and repeat codes bypass the FIFO; only fresh key codes enter.
// - A 17th byte becomes the overrun code; later scan data is dropped until that code has been sent.
// - Overrun code is 00h in sets 2 and 3, FFh in set 1.
// - A multi-byte code is queued only if all its bytes fit.
// - Start a frame only while the host leaves the clock line high.
// - Each frame is 11 bits, clocked by the keyboard.
// - Clock low 41 us, high 30 to 40 us, 20 us high before start.
// - Host inhibits by holding clock low; check it at least every 60 us.
// - Inhibit from the first clock to the parity rising edge finishes; earlier or later aborts, keeping byte.
// - Three code sets, set 2 after reset; set 3 keys have own modes.
// - A key held over 500 ms repeats its make code at 10-12 Hz.
// - Only the most recently pressed key repeats.
// - Pause never repeats; in sets 1 and 2 the internet button does not either, other keys do; set 3 repeats KM_RPT keys only.
module kst_keyboard
    import kst_pkg::*;
#(
    parameter int NUM_KEYS = 16,
    parameter int PAUSE_KEY = 15,
    parameter logic [NUM_KEYS-1:0] NO_RPT = 16'h4000,
    parameter int POR_US = POR_MS * 1000,
    parameter int TEST_US = TEST_MS * 1000,
    parameter int SCAN_US = SCAN_MS * 1000,
    parameter int RPT_DLY_US = RPT_DLY_MS * 1000,
    parameter int RPT_PER_US = 1000000 / RPT_HZ,
    parameter int TICK_CYC = US_CYC
) (
    input wire logic clk, // 100 MHz clock
    input wire logic rst_n, // Power-on reset
    input wire logic [NUM_KEYS-1:0] keysRaw, // Key closures, async
    input wire kst_kmode_e [NUM_KEYS-1:0] keyMode, // Per-key mode, set 3
    input wire logic setLoad, // Pulse: take setSel
    input wire kst_set_e setSel, // Code set to use
    input wire logic cmdValid, // Pulse: host command seen
    input wire kst_lin_s linkIn, // Line levels, async
    output kst_lout_s linkOut, // Open-drain drives
    output logic running, // Scanning enabled
    output logic testFail // Self-test failed
);
    localparam int IW = $clog2(NUM_KEYS);
    typedef enum logic [2:0] {
        M_POR, M_TEST, M_RESP, M_HALT, M_IDLE, M_WALK, M_EMIT
    } kst_main_e;
    typedef enum logic [1:0] {T_IDLE, T_HIGH, T_LOW} kst_tx_e;

    kst_main_e st_q, st_d, nxtSt;
    kst_tx_e tx_q, tx_d;
    kst_set_e set_q, set_d;
    kst_src_e src_q, src_d, src;
    kst_kmode_e mode;
    logic [NUM_KEYS-1:0] keyS1_q, keyS_q, keySt_q, keySt_d;
    kst_lin_s linS1_q, linS_q;
    logic [6:0] pre_q, pre_d;
    logic [19:0] usCnt_q, usCnt_d, rCnt_q, rCnt_d;
    logic [IW-1:0] idx_q, idx_d, nxtIdx, rKey_q, rKey_d;
    logic [15:0] seq_q, seq_d;
    logic [1:0] len_q, len_d, needLen;
    logic [7:0] resp_q, resp_d, make, txByte;
    logic respV_q, respV_d, fail_q, fail_d, ovr_q, ovr_d;
    logic rOn_q, rOn_d, rFirst_q, rFirst_d, rPend_q, rPend_d;
    logic [3:0] bit_q, bit_d;
    logic [5:0] ph_q, ph_d, lim;
    logic [10:0] frm_q, frm_d;
    logic clkOeN_q, clkOeN_d, datOeN_q, datOeN_d;
    logic usTick, lastIdx, keyNow, chg, pressEv, relEv, emit, fits, set3;
    logic run, have, inhibit, phEnd, done, rFire;
    logic respTake, fPop, ovrTake, rptTake, fWr, fInReady, fOutValid;
    logic [7:0] fOut;
    logic [$clog2(FIFO_DEPTH):0] fCnt;
    logic [12:0] lowRun_q;

    function automatic logic [7:0] mkCode(input logic [IW-1:0] k,
                                          input kst_set_e s);
        mkCode = (s == SET1 ? MK_BASE1 : MK_BASE23) + 8'(k);
    endfunction : mkCode

    // Two flops on the key and line pins before any logic looks at them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            keyS1_q <= '0;
            keyS_q <= '0;
            linS1_q <= '1;
            linS_q <= '1;
        end else begin
            keyS1_q <= keysRaw;
            keyS_q <= keyS1_q;
            linS1_q <= linkIn;
            linS_q <= linS1_q;
        end
    end

    // Startup, scan walk, queue writes and auto-repeat
    always_comb begin
        usTick = pre_q == 7'(TICK_CYC - 1);
        pre_d = usTick ? 7'h0 : pre_q + 7'h1;
        st_d = st_q;
        usCnt_d = usTick ? usCnt_q + 20'h1 : usCnt_q;
        idx_d = idx_q;
        keySt_d = keySt_q;
        seq_d = seq_q;
        len_d = len_q;
        resp_d = resp_q;
        respV_d = respV_q & ~respTake;
        fail_d = fail_q;
        ovr_d = ovr_q & ~ovrTake;
        set_d = setLoad ? setSel : set_q;
        set3 = set_q == SET3;
        fWr = 1'b0;
        lastIdx = idx_q == IW'(NUM_KEYS - 1);
        nxtSt = lastIdx ? M_IDLE : M_WALK;
        nxtIdx = lastIdx ? idx_q : idx_q + IW'(1);
        keyNow = keyS_q[idx_q];
        make = mkCode(idx_q, set_q);
        mode = keyMode[idx_q];
        chg = st_q == M_WALK && keyNow != keySt_q[idx_q];
        pressEv = chg && keyNow;
        relEv = chg && !keyNow;
        emit = (pressEv && !(set3 && mode == KM_BRKONLY))
            || (relEv && idx_q != IW'(PAUSE_KEY)
                && !(set3 && mode == KM_MKONLY));
        needLen = (relEv && set_q != SET1) ? 2'h2 : 2'h1;
        fits = 6'(fCnt) + 6'(needLen) <= 6'(FIFO_DEPTH);
        case (st_q)
            M_POR: if (usCnt_q >= 20'(POR_US)) begin
                st_d = M_TEST;
                usCnt_d = '0;
            end
            M_TEST: begin
                keySt_d = keyS_q;
                if (usCnt_q >= 20'(TEST_US)) begin
                    fail_d = |keyS_q; // A key closed at rest is a short
                    resp_d = |keyS_q ? CODE_FAIL : CODE_PASS;
                    respV_d = 1'b1;
                    st_d = M_RESP;
                end
            end
            M_RESP: if (!respV_q) begin
                st_d = fail_q ? M_HALT : M_IDLE;
                usCnt_d = '0;
            end
            M_HALT: if (cmdValid) begin
                fail_d = 1'b0;
                keySt_d = keyS_q;
                st_d = M_IDLE;
            end
            M_IDLE: if (usCnt_q >= 20'(SCAN_US)) begin
                st_d = M_WALK;
                idx_d = '0;
                usCnt_d = '0;
            end
            M_WALK: begin
                keySt_d[idx_q] = keyNow;
                seq_d = pressEv ? {make, 8'h00} :
                    set_q == SET1 ? {make | BRK_BIT1, 8'h00} :
                    {BRK_PFX, make};
                len_d = needLen;
                if (emit && fits && !ovr_q) begin
                    st_d = M_EMIT;
                end else begin
                    // Dropped keystrokes are lost, state still tracks keys
                    ovr_d = ovr_d | emit;
                    st_d = nxtSt;
                    idx_d = nxtIdx;
                end
            end
            M_EMIT: begin
                fWr = 1'b1;
                if (fInReady) begin
                    seq_d = {seq_q[7:0], 8'h00};
                    len_d = len_q - 2'h1;
                    if (len_q == 2'h1) begin
                        st_d = nxtSt;
                        idx_d = nxtIdx;
                    end
                end
            end
            default: st_d = M_POR;
        endcase
        rKey_d = rKey_q;
        rOn_d = rOn_q;
        rCnt_d = rCnt_q;
        rFirst_d = rFirst_q;
        rFire = rOn_q && usTick
            && rCnt_q >= 20'(rFirst_q ? RPT_DLY_US : RPT_PER_US);
        if (pressEv) begin
            rKey_d = idx_q;
            rOn_d = idx_q != IW'(PAUSE_KEY)
                && (set3 ? mode == KM_RPT : !NO_RPT[idx_q]);
            rCnt_d = '0;
            rFirst_d = 1'b1;
        end else if (relEv && idx_q == rKey_q) begin
            rOn_d = 1'b0;
        end else if (rFire) begin
            rCnt_d = '0;
            rFirst_d = 1'b0;
        end else if (rOn_q && usTick) begin
            rCnt_d = rCnt_q + 20'h1;
        end
        // A fire in the release cycle must not leave a stale repeat behind
        rPend_d = ((rPend_q & ~rptTake) | rFire) & rOn_d;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_q <= '0;
            st_q <= M_POR;
            usCnt_q <= '0;
            idx_q <= '0;
            keySt_q <= '0;
            seq_q <= '0;
            len_q <= '0;
            resp_q <= '0;
            respV_q <= 1'b0;
            fail_q <= 1'b0;
            ovr_q <= 1'b0;
            set_q <= SET2;
            rKey_q <= '0;
            rOn_q <= 1'b0;
            rCnt_q <= '0;
            rFirst_q <= 1'b0;
            rPend_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            st_q <= st_d;
            usCnt_q <= usCnt_d;
            idx_q <= idx_d;
            keySt_q <= keySt_d;
            seq_q <= seq_d;
            len_q <= len_d;
            resp_q <= resp_d;
            respV_q <= respV_d;
            fail_q <= fail_d;
            ovr_q <= ovr_d;
            set_q <= set_d;
            rKey_q <= rKey_d;
            rOn_q <= rOn_d;
            rCnt_q <= rCnt_d;
            rFirst_q <= rFirst_d;
            rPend_q <= rPend_d;
        end
    end

    kst_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(fWr),
        .inReady(fInReady),
        .inData(seq_q[15:8]),
        .outValid(fOutValid),
        .outReady(fPop),
        .outData(fOut),
        .count(fCnt)
    );

    // Serial sender; the head byte is only released once its frame ends
    always_comb begin
        tx_d = tx_q;
        bit_d = bit_q;
        ph_d = usTick ? ph_q + 6'h1 : ph_q;
        frm_d = frm_q;
        src_d = src_q;
        clkOeN_d = clkOeN_q;
        datOeN_d = datOeN_q;
        done = 1'b0;
        run = st_q == M_IDLE || st_q == M_WALK || st_q == M_EMIT;
        have = 1'b1;
        src = S_RESP;
        txByte = resp_q;
        if (respV_q) begin
            src = S_RESP;
        end else if (run && fOutValid) begin
            src = S_FIFO;
            txByte = fOut;
        end else if (run && ovr_q) begin
            src = S_OVR;
            txByte = set_q == SET1 ? OVR_SET1 : OVR_SET23;
        end else if (run && rPend_q) begin
            src = S_RPT;
            txByte = mkCode(rKey_q, set_q);
        end else begin
            have = 1'b0;
        end
        // Clock released long enough for the line to settle
        inhibit = !linS_q.clk && ph_q != 6'h0;
        lim = tx_q == T_LOW ? 6'(T_LOW_US) :
            bit_q == 4'h0 ? 6'(T_HBT_US) : 6'(T_HIGH_US);
        phEnd = usTick && ph_q == lim - 6'h1;
        case (tx_q)
            T_IDLE: if (have && linS_q.clk && linS_q.dat) begin
                frm_d = {1'b1, ~^txByte, txByte, 1'b0};
                src_d = src;
                bit_d = '0;
                ph_d = '0;
                datOeN_d = 1'b0;
                tx_d = T_HIGH;
            end
            T_HIGH: if (inhibit && (bit_q == 4'h0 || bit_q > PAR_BIT)) begin
                tx_d = T_IDLE;
                datOeN_d = 1'b1;
            end else if (phEnd) begin
                tx_d = T_LOW;
                clkOeN_d = 1'b0;
                ph_d = '0;
            end
            T_LOW: if (phEnd) begin
                clkOeN_d = 1'b1;
                ph_d = '0;
                if (bit_q == 4'(FRAME_BITS - 1)) begin
                    done = 1'b1;
                    datOeN_d = 1'b1;
                    tx_d = T_IDLE;
                end else begin
                    bit_d = bit_q + 4'h1;
                    frm_d = frm_q >> 1;
                    datOeN_d = frm_q[1];
                    tx_d = T_HIGH;
                end
            end
            default: tx_d = T_IDLE;
        endcase
        respTake = done && src_q == S_RESP;
        fPop = done && src_q == S_FIFO;
        ovrTake = done && src_q == S_OVR;
        rptTake = done && src_q == S_RPT;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_q <= T_IDLE;
            bit_q <= '0;
            ph_q <= '0;
            frm_q <= '1;
            src_q <= S_RESP;
            clkOeN_q <= 1'b1;
            datOeN_q <= 1'b1;
        end else begin
            tx_q <= tx_d;
            bit_q <= bit_d;
            ph_q <= ph_d;
            frm_q <= frm_d;
            src_q <= src_d;
            clkOeN_q <= clkOeN_d;
            datOeN_q <= datOeN_d;
        end
    end

    // Lines are only ever pulled low; release lets the pull-up win
    always_comb begin
        linkOut.clkOut = 1'b0;
        linkOut.clkOeN = clkOeN_q;
        linkOut.datOut = 1'b0;
        linkOut.datOeN = datOeN_q;
        running = run;
        testFail = fail_q;
    end

    // Length of the current clock-low stretch, for checking only
    always_ff @(posedge clk) begin
        if (!rst_n || clkOeN_q) begin
            lowRun_q <= '0;
        end else begin
            lowRun_q <= lowRun_q + 13'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_low_phase: assert property ($rose(linkOut.clkOeN) |->
        lowRun_q == 13'(T_LOW_US * TICK_CYC))
        else $error("clock low phase length wrong");
    a_start_bit: assert property ((tx_q == T_IDLE && tx_d == T_HIGH)
        |=> !linkOut.datOeN && linkOut.clkOeN)
        else $error("start bit not driven low");
    a_inhibit_wait: assert property ((tx_q == T_IDLE && !linS_q.clk)
        |=> tx_q == T_IDLE)
        else $error("frame started while host inhibits");
    a_late_abort: assert property ((tx_q == T_HIGH && bit_q > PAR_BIT
        && inhibit) |-> !fPop && !respTake ##1 tx_q == T_IDLE)
        else $error("late inhibit did not abort and keep byte");
    a_early_finish: assert property ((tx_q == T_HIGH && bit_q != 4'h0
        && bit_q <= PAR_BIT) |=> tx_q != T_IDLE)
        else $error("frame dropped before parity edge");
    a_pause_nobrk: assert property ((relEv
        && idx_q == IW'(PAUSE_KEY)) |=> st_q != M_EMIT && !$rose(ovr_q))
        else $error("pause key produced a break code");
    a_queue_src: assert property (fWr |-> st_q == M_EMIT)
        else $error("non-key byte written to queue");
    a_seq_fits: assert property ((st_q == M_WALK && st_d == M_EMIT) |->
        6'(fCnt) + 6'(len_d) <= 6'(FIFO_DEPTH))
        else $error("sequence queued without room");
    a_ovr_code: assert property ((tx_q == T_IDLE && tx_d == T_HIGH
        && src == S_OVR) |=> frm_q[8:1] ==
        ($past(set_q) == SET1 ? OVR_SET1 : OVR_SET23))
        else $error("wrong overrun code");
    a_reset_set: assert property ($past(!rst_n) |-> set_q == SET2)
        else $error("code set not 2 after reset");
    a_test_code: assert property ((st_q == M_TEST && st_d == M_RESP)
        |=> respV_q && resp_q == (fail_q ? CODE_FAIL : CODE_PASS))
        else $error("self-test result code wrong");

    c_frame_done: cover property (done && src_q == S_FIFO);
    c_overrun: cover property (ovrTake);
    c_repeat: cover property (rptTake);
    c_abort: cover property (tx_q == T_HIGH && tx_d == T_IDLE);
endmodule : kst_keyboard

// >>> dv/kst_host_model.sv
// Behavioural host controller that takes keyboard frames off the link
module kst_host_model
    import kst_pkg::*;
#(
    parameter real TICK_NS = 1000.0 // Length of one device timing tick
) (
    input wire logic lineClk, // Resolved clock line
    input wire logic lineDat, // Resolved data line
    input wire logic inhibit, // Host holds the clock line low
    output logic [7:0] rxByte, // Last byte taken
    output logic kbdIrq, // Host keyboard interrupt line, pulse per byte
    output logic [7:0] errCount // Bad frames or clock phases
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] frame;
    int nBits;
    realtime tFall;

    // Host starts quiet with no partial frame
    initial begin
        rxByte = 8'h00;
        kbdIrq = 1'b0;
        errCount = 8'h00;
        nBits = 0;
        tFall = 0;
    end

    // Bits are taken while the clock is low; inhibit edges are ignored
    always @(negedge lineClk) begin
        if (!inhibit && nBits < FRAME_BITS) begin
            tFall = $realtime;
            frame[nBits] = lineDat;
            nBits++;
        end
    end

    // An inhibit throws away any partial frame
    always @(posedge inhibit) begin
        nBits = 0;
    end

    // Low phase length, then framing once all bits are in
    always @(posedge lineClk) begin
        if (nBits > 0 && $realtime - tFall != T_LOW_US * TICK_NS) begin
            errCount = errCount + 8'h01;
        end
        if (nBits == FRAME_BITS) begin
            nBits = 0;
            if (frame[0] || !frame[10] || !(^frame[9:1])) begin
                errCount = errCount + 8'h01;
            end
            rxByte = frame[8:1];
            kbdIrq = 1'b1;
            #1;
            kbdIrq = 1'b0;
        end
    end
endmodule : kst_host_model

// >>> dv/test_kst_keyboard.sv
// Self-checking bench for the keyboard scanner and serial sender
module test_kst_keyboard
    import kst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rstN;
    logic [15:0] keysRaw;
    kst_kmode_e [15:0] keyMode;
    logic setLoad;
    kst_set_e setSel;
    logic cmdValid;
    kst_lin_s linkIn;
    kst_lout_s linkOut;
    logic running;
    logic testFail;
    logic inhibit;
    logic lineClk;
    logic lineDat;
    logic [7:0] rxByte;
    logic kbdIrq;
    logic [7:0] errCount;
    logic [7:0] expQ[$];
    int mismatches = 0;
    int testsRun = 0;
    int cycles = 0;

    // Open-drain lines with pull-ups; the host may pull the clock low
    assign lineClk = linkOut.clkOeN & ~inhibit;
    assign lineDat = linkOut.datOeN;
    assign linkIn = {lineClk, lineDat};

    // Short counts and a 4-cycle tick keep the run affordable
    kst_keyboard #(.POR_US(20), .TEST_US(30), .SCAN_US(50),
        .RPT_DLY_US(200), .RPT_PER_US(100), .TICK_CYC(4)) dut_u (
        .clk(clk), .rst_n(rstN), .keysRaw(keysRaw), .keyMode(keyMode),
        .setLoad(setLoad), .setSel(setSel), .cmdValid(cmdValid),
        .linkIn(linkIn), .linkOut(linkOut), .running(running),
        .testFail(testFail));

    kst_host_model #(.TICK_NS(40.0)) host_u (.lineClk(lineClk),
        .lineDat(lineDat), .inhibit(inhibit), .rxByte(rxByte),
        .kbdIrq(kbdIrq), .errCount(errCount));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [7:0] lfsr_next(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (mismatches == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset();
        rstN = 1'b0;
        repeat (4) @(negedge clk);
        rstN = 1'b1;
    endtask : do_reset

    // Wait for every expected byte, then let the link settle
    task automatic drain();
        while (expQ.size() != 0) @(negedge clk);
        repeat (100) @(negedge clk);
    endtask : drain

    // Each received byte is matched against the oldest note; a byte with no note left is a mismatch
    always @(posedge kbdIrq) begin
        if (expQ.size() == 0) begin
            check("spare byte", rxByte, 8'hxx);
        end else begin
            check("rx byte", rxByte, expQ.pop_front());
        end
    end

    // A hang counts as a mismatch; the whole run needs about 50k cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        logic [7:0] lfsr;
        logic [7:0] mk;
        logic sawDrive;
        int k;
        int j;
        lfsr = 8'h0c;
        rstN = 1'b0;
        keysRaw = '0;
        keyMode = {16{KM_RPT}};
        setLoad = 1'b0;
        setSel = SET2;
        cmdValid = 1'b0;
        inhibit = 1'b0;
        // A key closed at test end fails the self-test
        @(negedge clk);
        keysRaw[3] = 1'b1;
        do_reset();
        expQ.push_back(CODE_FAIL);
        drain();
        check("test fail", {7'h0, testFail}, 8'h01);
        keysRaw = '0;
        repeat (800) @(negedge clk);
        check("halted", {7'h0, running}, 8'h00);
        cmdValid = 1'b1;
        @(negedge clk);
        cmdValid = 1'b0;
        repeat (10) @(negedge clk);
        check("resumed", {7'h0, running}, 8'h01);
        check("fail cleared", {7'h0, testFail}, 8'h00);
        // Second reset with the host inhibiting: result waits for release
        inhibit = 1'b1;
        do_reset();
        sawDrive = 1'b0;
        repeat (1200) begin
            @(negedge clk);
            sawDrive = sawDrive | ~linkOut.datOeN;
        end
        check("quiet inhibited", {7'h0, sawDrive}, 8'h00);
        check("no scan yet", {7'h0, running}, 8'h00);
        expQ.push_back(CODE_PASS);
        inhibit = 1'b0;
        drain();
        check("scanning", {7'h0, running}, 8'h01);
        // Tap a random key in the default set, then in set 1
        for (int s = 0; s < 2; s++) begin
            lfsr = lfsr_next(lfsr);
            k = int'(lfsr) % 14;
            mk = (s == 0 ? MK_BASE23 : MK_BASE1) + 8'(k);
            if (s == 1) begin
                setSel = SET1;
                setLoad = 1'b1;
                @(negedge clk);
                setLoad = 1'b0;
            end
            expQ.push_back(mk);
            if (s == 0) begin
                expQ.push_back(BRK_PFX);
                expQ.push_back(mk);
            end else begin
                expQ.push_back(mk | BRK_BIT1);
            end
            // Held under the repeat delay so no repeat code follows
            keysRaw[k] = 1'b1;
            repeat (400) @(negedge clk);
            keysRaw[k] = 1'b0;
            drain();
        end
        // Pause held past the repeat delay: one make, no repeat or break
        expQ.push_back(MK_BASE1 + 8'h0f);
        keysRaw[15] = 1'b1;
        repeat (1600) @(negedge clk);
        keysRaw[15] = 1'b0;
        drain();
        // Two keys held in set 1: only the later one repeats, once
        lfsr = lfsr_next(lfsr);
        k = int'(lfsr) % 13;
        j = k + 1;
        mk = MK_BASE1 + 8'(k);
        expQ.push_back(mk);
        expQ.push_back(MK_BASE1 + 8'(j));
        expQ.push_back(MK_BASE1 + 8'(j));
        expQ.push_back(mk | BRK_BIT1);
        expQ.push_back((MK_BASE1 + 8'(j)) | BRK_BIT1);
        keysRaw[k] = 1'b1;
        repeat (400) @(negedge clk);
        keysRaw[j] = 1'b1;
        repeat (7600) @(negedge clk);
        keysRaw[k] = 1'b0;
        keysRaw[j] = 1'b0;
        drain();
        // Long enough for any stray frame to arrive as a spare byte
        repeat (4000) @(negedge clk);
        check("frame errors", errCount, 8'h00);
        finish_test();
    end
endmodule : test_kst_keyboard
